// ==== nps_defines.svh ====
/*
 * Constants for the NAND page program sequencer: opcodes, status bit
 * positions, page geometry, busy times and the host register map.
 * Assumes a 100 MHz system clock on both ends of the link.
 */
`ifndef NPS_DEFINES_SVH
`define NPS_DEFINES_SVH

`define NPS_CLK_NS 10
`define NPS_PROG_NS 200000
`define NPS_CBSY_NS 3000
`define NPS_DBSY_NS 500
`define NPS_CYC(ns) (((ns) + `NPS_CLK_NS - 1) / `NPS_CLK_NS)
`define NPS_PROG_CYC `NPS_CYC(`NPS_PROG_NS)
`define NPS_CBSY_CYC `NPS_CYC(`NPS_CBSY_NS)
`define NPS_DBSY_CYC `NPS_CYC(`NPS_DBSY_NS)

`define NPS_OP_SETUP 8'h80
`define NPS_OP_COLCHG 8'h85
`define NPS_OP_PROG 8'h10
`define NPS_OP_CACHE 8'h15
`define NPS_OP_QUEUE 8'h11
`define NPS_OP_STAT 8'h70
`define NPS_OP_STATX 8'h78

`define NPS_ST_FAIL 0
`define NPS_ST_CACHE_FAIL_FLAG 1
`define NPS_ST_PFAIL 2
`define NPS_ST_PFAILC 4
`define NPS_ST_PFAILC1 7
`define NPS_ST_ARRAY_READY_FLAG 5
`define NPS_ST_RDY 6

`define NPS_PAGE_BYTES 4352
`define NPS_STATX_ADDR 4'h3
`define NPS_DIE_ROW 8'h00

`define NPS_REG_CTRL 4'h0
`define NPS_REG_STATUS 4'h4
`define NPS_REG_DIE 4'h8
`define NPS_DIE_RST 9'h100

`endif

// ==== nps_pkg.sv ====
/*
 * Types shared by both ends of the page program sequencer.
 * Assumes nps_defines.svh for all numeric constants.
 */
package nps_pkg;

typedef enum logic [1:0] {
	NPS_PH_IDLE = 2'b00,
	NPS_PH_ADDR = 2'b01,
	NPS_PH_DATA = 2'b10
} nps_phase_t;

typedef enum logic [1:0] {
	NPS_FR_IDLE = 2'b00,
	NPS_FR_WAIT = 2'b01,
	NPS_FR_CBSY = 2'b10,
	NPS_FR_DBSY = 2'b11
} nps_front_t;

typedef enum logic [2:0] {
	NPS_E_IDLE = 3'b000,
	NPS_E_PCMD = 3'b001,
	NPS_E_PADR = 3'b010,
	NPS_E_PRE = 3'b011,
	NPS_E_PCAP = 3'b100
} nps_eng_t;

endpackage : nps_pkg

// ==== nps_link_if.sv ====
/*
 * Synchronous NAND-style link between host controller and die.
 * Assumes both ends run on the same clock; the shared data bus is
 * resolved here from the two output enables.
 */
`timescale 1ns/1ns
interface nps_link_if;
	logic cle;
	logic ale;
	logic we;
	logic re;
	logic [7:0] dq_h;
	logic dq_h_oe;
	logic [7:0] dq_d;
	logic dq_d_oe;
	logic rb_n;
	logic [7:0] dq;

	assign dq = dq_d_oe ? dq_d : (dq_h_oe ? dq_h : 8'hFF);

	modport dev (input cle, input ale, input we, input re, input dq, output dq_d,
		output dq_d_oe, output rb_n);
	modport host (output cle, output ale, output we, output re, output dq_h,
		output dq_h_oe, input dq, input rb_n);
endinterface : nps_link_if

// ==== nps_die.sv ====
/*
 * Die end of the page program sequencer: command decode, cache
 * registers, busy timing and status byte.
 * Assumes the host drives one link cycle per clock with we or re high.
 */
// Overview of operation
// - Setup opcode clears caches unless planes queued.
// - Address cycles set column; data stored from there.
// - Column change commands accepted during data input.
// - Confirm 10h clears both ready flags for program.
// - Host polls ready pin or status, checks fail.
// - Host selects die with enhanced status command.
// - Final 10h programs all queued planes together.
// - Cached program copies cache, then programs array.
// - Cached program accepted when ready flag set.
// - Confirm 15h: wait, cache busy, copy, start.
// - Host checks cache fail during cached program.
// - Host waits array ready, checks both fails.
// - Final 15h moves all queued planes together.
// - Each queue command loads and queues its plane.
// - Queue command accepted whenever ready flag set.
// - Confirm 11h gives dummy busy time.
// - After dummy busy host queues or confirms.
// - Host checks fail per plane after 10h.
// - Cached copy waits for earlier array work.
// - Host programs pages in ascending order.
// - Status bit 6 is the ready flag.
`timescale 1ns/1ns
`include "nps_defines.svh"
module nps_die
	import nps_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = `NPS_PROG_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	nps_link_if.dev lnk,
	input wire logic [1:0] fail_inject,
	input wire logic peek_plane,
	input wire logic [12:0] peek_col,
	output logic [7:0] peek_data,
	output logic prog_pulse,
	output logic [1:0] prog_planes
);

typedef struct packed {
	nps_phase_t phase;
	nps_front_t front;
	logic wait_cache;
	logic [19:0] fcnt;
	logic [19:0] acnt;
	logic arr_busy;
	logic rdy;
	logic in_seq;
	logic [1:0] queue;
	logic [1:0] moving;
	logic plane;
	logic [2:0] acount;
	logic [12:0] col;
	logic fail;
	logic cache_fail_flag;
	logic [1:0] pfail;
	logic [1:0] pfailc;
	logic stat_sel;
	logic [1:0] stat_acnt;
	logic [7:0] dq_out;
	logic dq_oe;
	logic rb_n;
	logic prog_pulse;
	logic [1:0] prog_planes;
} nps_die_st_t;

localparam nps_die_st_t RST = '{phase: NPS_PH_IDLE, front: NPS_FR_IDLE, rdy: 1'b1,
	stat_sel: 1'b1, dq_out: 8'hFF, rb_n: 1'b1, default: '0};

nps_die_st_t s_reg;
nps_die_st_t s_next;
logic [7:0] cache_mem [2][`NPS_PAGE_BYTES];
logic wr_en;
logic clr_en;
logic [7:0] peek_reg;

////////////////////////////////////////////////////////////////////////////////

// Starting the array takes every queued plane at once.
function automatic nps_die_st_t start_array(input nps_die_st_t st);
	nps_die_st_t r;
	r = st;
	r.arr_busy = 1'b1;
	r.acnt = 20'(PROG_CYCLES);
	r.moving = st.queue;
	r.queue = 2'b00;
	return r;
endfunction : start_array

function automatic logic [7:0] status_byte(input nps_die_st_t st);
	logic [7:0] b;
	b = 8'h00;
	b[`NPS_ST_RDY] = st.rdy;
	b[`NPS_ST_ARRAY_READY_FLAG] = st.rdy & ~st.arr_busy;
	b[`NPS_ST_FAIL] = st.fail;
	b[`NPS_ST_CACHE_FAIL_FLAG] = st.cache_fail_flag;
	b[`NPS_ST_PFAIL +: 2] = st.pfail;
	b[`NPS_ST_PFAILC] = st.pfailc[0];
	b[`NPS_ST_PFAILC1] = st.pfailc[1];
	return b;
endfunction : status_byte

////////////////////////////////////////////////////////////////////////////////

always_comb begin
	s_next = s_reg;
	s_next.dq_oe = 1'b0;
	s_next.prog_pulse = 1'b0;
	wr_en = 1'b0;
	clr_en = 1'b0;
	if (s_reg.arr_busy) begin
		if (s_reg.acnt <= 20'h00001) begin
			s_next.arr_busy = 1'b0;
			s_next.prog_pulse = 1'b1;
			s_next.prog_planes = s_reg.moving;
			s_next.pfail = fail_inject & s_reg.moving;
			s_next.fail = |(fail_inject & s_reg.moving);
			if (s_reg.front == NPS_FR_IDLE) begin
				s_next.rdy = 1'b1;
			end
		end else begin
			s_next.acnt = s_reg.acnt - 20'h00001;
		end
	end
	case (s_reg.front)
		NPS_FR_WAIT: begin
			if (!s_reg.arr_busy) begin
				if (s_reg.wait_cache) begin
					s_next.front = NPS_FR_CBSY;
					s_next.fcnt = 20'(`NPS_CBSY_CYC);
				end else begin
					s_next = start_array(s_next);
					s_next.front = NPS_FR_IDLE;
				end
			end
		end
		NPS_FR_CBSY: begin
			if (s_reg.fcnt <= 20'h00001) begin
				s_next = start_array(s_next);
				s_next.cache_fail_flag = s_reg.fail;
				s_next.pfailc = s_reg.pfail;
				s_next.front = NPS_FR_IDLE;
				s_next.rdy = 1'b1;
			end else begin
				s_next.fcnt = s_reg.fcnt - 20'h00001;
			end
		end
		NPS_FR_DBSY: begin
			if (s_reg.fcnt <= 20'h00001) begin
				s_next.front = NPS_FR_IDLE;
				s_next.rdy = 1'b1;
			end else begin
				s_next.fcnt = s_reg.fcnt - 20'h00001;
			end
		end
		default: begin
		end
	endcase
	if (lnk.we && lnk.cle) begin
		case (lnk.dq)
			`NPS_OP_SETUP: begin
				if (s_reg.rdy) begin
					clr_en = (s_reg.queue == 2'b00);
					s_next.in_seq = 1'b1;
					s_next.phase = NPS_PH_ADDR;
					s_next.acount = 3'd0;
				end
			end
			`NPS_OP_COLCHG: begin
				if (s_reg.in_seq && s_reg.phase != NPS_PH_IDLE) begin
					s_next.phase = NPS_PH_ADDR;
					s_next.acount = 3'd0;
				end
			end
			`NPS_OP_PROG, `NPS_OP_CACHE, `NPS_OP_QUEUE: begin
				if (s_reg.in_seq && s_reg.rdy) begin
					s_next.queue[s_reg.plane] = 1'b1;
					s_next.in_seq = 1'b0;
					s_next.phase = NPS_PH_IDLE;
					s_next.rdy = 1'b0;
					s_next.wait_cache = (lnk.dq == `NPS_OP_CACHE);
					s_next.front = NPS_FR_WAIT;
					if (lnk.dq == `NPS_OP_QUEUE) begin
						s_next.front = NPS_FR_DBSY;
						s_next.fcnt = 20'(`NPS_DBSY_CYC);
					end
				end
			end
			`NPS_OP_STAT: begin
				s_next.stat_sel = 1'b1;
				s_next.stat_acnt = 2'd0;
			end
			`NPS_OP_STATX: begin
				s_next.stat_acnt = 2'(`NPS_STATX_ADDR);
			end
			default: begin
			end
		endcase
	end else if (lnk.we && lnk.ale) begin
		if (s_reg.stat_acnt != 2'd0) begin
			s_next.stat_acnt = s_reg.stat_acnt - 2'd1;
			if (s_reg.stat_acnt == 2'd1) begin
				s_next.stat_sel = (lnk.dq == `NPS_DIE_ROW);
			end
		end else if (s_reg.phase == NPS_PH_ADDR) begin
			case (s_reg.acount)
				3'd0: s_next.col[7:0] = lnk.dq;
				3'd1: s_next.col[12:8] = lnk.dq[4:0];
				3'd2: s_next.plane = lnk.dq[6];
				default: begin
				end
			endcase
			if (s_reg.acount != 3'd7) begin
				s_next.acount = s_reg.acount + 3'd1;
			end
		end
	end else if (lnk.we && s_reg.phase != NPS_PH_IDLE) begin
		wr_en = (s_reg.col < 13'(`NPS_PAGE_BYTES));
		s_next.col = s_reg.col + 13'd1;
		s_next.phase = NPS_PH_DATA;
	end
	if (lnk.re) begin
		s_next.dq_oe = s_reg.stat_sel;
		s_next.dq_out = status_byte(s_reg);
	end
	s_next.rb_n = s_next.rdy;
end

always_ff @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		s_reg <= RST;
	end else begin
		s_reg <= s_next;
	end
end

// One-cycle clear of every cache byte trades area for a sequence with no wait.
always_ff @(posedge hclk) begin
	if (clr_en) begin
		for (int p = 0; p < 2; p++) begin
			for (int c = 0; c < `NPS_PAGE_BYTES; c++) begin
				cache_mem[p][c] <= 8'hFF;
			end
		end
	end else if (wr_en) begin
		cache_mem[s_reg.plane][s_reg.col] <= lnk.dq;
	end
	if (peek_col < 13'(`NPS_PAGE_BYTES)) begin
		peek_reg <= cache_mem[peek_plane][peek_col];
	end
end

assign peek_data = peek_reg;
assign lnk.dq_d = s_reg.dq_out;
assign lnk.dq_d_oe = s_reg.dq_oe;
assign lnk.rb_n = s_reg.rb_n;
assign prog_pulse = s_reg.prog_pulse;
assign prog_planes = s_reg.prog_planes;

endmodule : nps_die

// ==== nps_host.sv ====
/*
 * Host end: AHB-Lite register slave that issues link cycles and polls
 * the die status until the requested ready flags are set.
 * Assumes one AHB master and the die on the same clock.
 */
`timescale 1ns/1ns
`include "nps_defines.svh"
module nps_host
	import nps_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	nps_link_if.host lnk
);

typedef struct packed {
	nps_eng_t eng;
	logic cle;
	logic ale;
	logic we;
	logic re;
	logic [7:0] dq;
	logic dq_oe;
	logic wait_both;
	logic [1:0] padr;
	logic [7:0] stat;
	logic [8:0] die;
	logic order_err;
	logic [2:0] sacnt;
	logic [23:0] row;
	logic have_last;
	logic [17:0] last_blk;
	logic [5:0] last_page;
	logic dp_valid;
	logic dp_write;
	logic [3:0] dp_addr;
	logic rdy_o;
	logic [31:0] rdata;
} nps_host_st_t;

localparam nps_host_st_t RST = '{eng: NPS_E_IDLE, die: `NPS_DIE_RST, rdy_o: 1'b1,
	default: '0};

nps_host_st_t s_reg;
nps_host_st_t s_next;
logic take;
logic busy_next;

////////////////////////////////////////////////////////////////////////////////

always_comb begin
	s_next = s_reg;
	s_next.we = 1'b0;
	s_next.re = 1'b0;
	s_next.dq_oe = 1'b0;
	take = hsel && htrans[1] && hready;
	case (s_reg.eng)
		NPS_E_PCMD: begin
			s_next.we = 1'b1;
			s_next.cle = 1'b1;
			s_next.ale = 1'b0;
			s_next.dq_oe = 1'b1;
			s_next.dq = s_reg.die[8] ? `NPS_OP_STATX : `NPS_OP_STAT;
			s_next.padr = 2'd0;
			s_next.eng = s_reg.die[8] ? NPS_E_PADR : NPS_E_PRE;
		end
		NPS_E_PADR: begin
			s_next.we = 1'b1;
			s_next.cle = 1'b0;
			s_next.ale = 1'b1;
			s_next.dq_oe = 1'b1;
			s_next.dq = (s_reg.padr == 2'd2) ? s_reg.die[7:0] : 8'h00;
			s_next.padr = s_reg.padr + 2'd1;
			if (s_reg.padr == 2'd2) begin
				s_next.eng = NPS_E_PRE;
			end
		end
		NPS_E_PRE: begin
			s_next.re = 1'b1;
			s_next.eng = NPS_E_PCAP;
		end
		NPS_E_PCAP: begin
			// The die answers one cycle after re, so the cycle that still shows re is skipped.
			if (!s_reg.re) begin
				s_next.stat = lnk.dq;
				s_next.re = 1'b1;
				// Waiting only on the ready flag lets queued or cached work continue.
				if (lnk.dq[`NPS_ST_RDY] && (!s_reg.wait_both || lnk.dq[`NPS_ST_ARRAY_READY_FLAG])) begin
					s_next.re = 1'b0;
					s_next.eng = NPS_E_IDLE;
				end
			end
		end
		default: begin
		end
	endcase
	if (s_reg.dp_valid && s_reg.rdy_o) begin
		s_next.dp_valid = 1'b0;
		if (s_reg.dp_write && s_reg.dp_addr == `NPS_REG_CTRL) begin
			s_next.dq = hwdata[7:0];
			s_next.cle = (hwdata[9:8] == 2'd0);
			s_next.ale = (hwdata[9:8] == 2'd1);
			s_next.we = (hwdata[9:8] != 2'd3);
			s_next.dq_oe = (hwdata[9:8] != 2'd3);
			s_next.wait_both = hwdata[11];
			if (hwdata[9:8] == 2'd3) begin
				s_next.eng = NPS_E_PCMD;
			end
			if (hwdata[9:8] == 2'd0 && hwdata[7:0] == `NPS_OP_SETUP) begin
				s_next.sacnt = 3'd0;
			end
			if (hwdata[9:8] == 2'd1 && s_reg.sacnt < 3'd5) begin
				s_next.sacnt = s_reg.sacnt + 3'd1;
				if (s_reg.sacnt >= 3'd2) begin
					s_next.row[8*(s_reg.sacnt-3'd2) +: 8] = hwdata[7:0];
				end
			end
			if (hwdata[9:8] == 2'd0 && (hwdata[7:0] == `NPS_OP_PROG ||
				hwdata[7:0] == `NPS_OP_CACHE || hwdata[7:0] == `NPS_OP_QUEUE)) begin
				if (s_reg.have_last && s_reg.row[23:6] == s_reg.last_blk &&
					s_reg.row[5:0] <= s_reg.last_page) begin
					s_next.order_err = 1'b1;
				end
				s_next.have_last = 1'b1;
				s_next.last_blk = s_reg.row[23:6];
				s_next.last_page = s_reg.row[5:0];
			end
		end else if (s_reg.dp_write && s_reg.dp_addr == `NPS_REG_STATUS) begin
			if (hwdata[9] && s_next.order_err == s_reg.order_err) begin
				s_next.order_err = 1'b0;
			end
		end else if (s_reg.dp_write && s_reg.dp_addr == `NPS_REG_DIE) begin
			s_next.die = hwdata[8:0];
		end
	end
	busy_next = (s_next.eng != NPS_E_IDLE) || s_next.we;
	if (s_reg.dp_valid && !s_reg.rdy_o) begin
		s_next.rdy_o = !busy_next;
	end
	if (take) begin
		s_next.dp_valid = 1'b1;
		s_next.dp_write = hwrite;
		s_next.dp_addr = haddr[3:0];
		s_next.rdy_o = !(hwrite && haddr[3:0] == `NPS_REG_CTRL && busy_next);
		case (haddr[3:0])
			`NPS_REG_STATUS: s_next.rdata = {21'h000000, lnk.rb_n, s_reg.order_err,
				s_reg.eng != NPS_E_IDLE, s_reg.stat};
			`NPS_REG_DIE: s_next.rdata = {23'h000000, s_reg.die};
			default: s_next.rdata = 32'h00000000;
		endcase
	end
end

always_ff @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		s_reg <= RST;
	end else begin
		s_reg <= s_next;
	end
end

assign hrdata = s_reg.rdata;
assign hreadyout = s_reg.rdy_o;
assign hresp = 1'b0;
assign lnk.cle = s_reg.cle;
assign lnk.ale = s_reg.ale;
assign lnk.we = s_reg.we;
assign lnk.re = s_reg.re;
assign lnk.dq_h = s_reg.dq;
assign lnk.dq_h_oe = s_reg.dq_oe;

endmodule : nps_host

// ==== nps_link_sva.sv ====
/*
 * Checker on the link between host end and die end.
 * Assumes the testbench wires every interface signal, clock and reset by name.
 */
`timescale 1ns/1ns
`include "nps_defines.svh"
module nps_link_sva #(
	parameter int unsigned PROG_CYCLES = 40
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic cle,
	input wire logic ale,
	input wire logic we,
	input wire logic re,
	input wire logic [7:0] dq_h,
	input wire logic dq_h_oe,
	input wire logic [7:0] dq_d,
	input wire logic dq_d_oe,
	input wire logic rb_n,
	input wire logic [7:0] dq
);
	logic in_seq;
	logic [7:0] last_op;
	logic [15:0] bcnt;
	logic conf;
	assign conf = we && cle && (dq == 8'h10 || dq == 8'h15 || dq == 8'h11);
	////////////////////////////////////////////////////////////////////////////////
	// Busy length is counted here, since a repetition of hundreds of cycles is too slow.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_seq <= 1'b0;
			last_op <= 8'h00;
			bcnt <= 16'h0000;
		end else begin
			if (we && cle && dq == 8'h80 && rb_n)
				in_seq <= 1'b1;
			else if (conf)
				in_seq <= 1'b0;
			if (conf && in_seq && rb_n)
				last_op <= dq;
			bcnt <= rb_n ? 16'h0000 : bcnt + 16'h0001;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	chk_confirm_drops_ready: assert property (conf && in_seq && rb_n |=> !rb_n)
		else $error("confirm did not drop ready");
	chk_prog_busy_time: assert property ($rose(rb_n) && last_op == 8'h10 |-> bcnt >= PROG_CYCLES)
		else $error("program busy too short");
	chk_cache_busy_time: assert property ($rose(rb_n) && last_op == 8'h15 |-> bcnt >= `NPS_CBSY_CYC)
		else $error("cache busy too short");
	chk_dummy_busy_time: assert property ($rose(rb_n) && last_op == 8'h11 |-> bcnt inside {[`NPS_DBSY_CYC:`NPS_DBSY_CYC + 1]})
		else $error("dummy busy length wrong");
	chk_status_answer: assert property (re |=> dq_d_oe)
		else $error("status read not answered");
	chk_status_once: assert property (dq_d_oe |=> !dq_d_oe)
		else $error("status byte held too long");
	chk_ready_bit: assert property (dq_d_oe |-> dq_d[6] == rb_n || dq_d[6] == $past(rb_n))
		else $error("status ready bit disagrees with pin");
	chk_array_ready_bit: assert property (dq_d_oe && dq_d[5] |-> dq_d[6])
		else $error("array ready without ready");
	chk_one_driver: assert property (!(dq_d_oe && dq_h_oe))
		else $error("both ends drive the bus");
	chk_write_drive: assert property (we |-> dq_h_oe && !(cle && ale))
		else $error("write cycle badly qualified");
endmodule : nps_link_sva

// ==== nand_page_program_sequencer_tb.sv ====
/*
 * Testbench: AHB-Lite master on the host end, die end behind the link.
 * Assumes a short program time parameter so that a run stays brief.
 */
`timescale 1ns/1ns
`include "nps_defines.svh"
module nand_page_program_sequencer_tb
	import nps_pkg::*;
;
	localparam int unsigned PC = 40;
	typedef struct packed {logic [7:0] op; logic [5:0] pg; logic [12:0] col; logic [7:0] dat;
		logic [1:0] fi; logic [7:0] st;} nps_row_t;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, peek_plane, prog_pulse;
	logic [31:0] haddr, hwdata, hrdata, s;
	logic [1:0] htrans, fail_inject, prog_planes;
	logic [2:0] hsize;
	logic [12:0] peek_col, prev;
	logic [7:0] peek_data;
	int miscompares = 0;
	int checks = 0;
	int pulses = 0;
	nps_row_t rows [4];
	nps_link_if lnk();
	nps_die #(.PROG_CYCLES(PC)) nps_die_inst (.hclk(hclk), .hresetn(hresetn), .lnk(lnk),
		.fail_inject(fail_inject), .peek_plane(peek_plane), .peek_col(peek_col),
		.peek_data(peek_data), .prog_pulse(prog_pulse), .prog_planes(prog_planes));
	nps_host nps_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lnk(lnk));
	nps_link_sva #(.PROG_CYCLES(PC)) nps_link_sva_inst (.hclk(hclk), .hresetn(hresetn),
		.cle(lnk.cle), .ale(lnk.ale), .we(lnk.we), .re(lnk.re), .dq_h(lnk.dq_h),
		.dq_h_oe(lnk.dq_h_oe), .dq_d(lnk.dq_d), .dq_d_oe(lnk.dq_d_oe), .rb_n(lnk.rb_n), .dq(lnk.dq));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	always @(posedge hclk) if (prog_pulse === 1'b1) pulses++;
	task test_done;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// A busy CTRL write stretches its data phase, so both phases wait on hreadyout.
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 5000);
		if (n >= 5000) begin miscompares++; test_done(); end
		htrans <= 2'h0;
		hwdata <= wd;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 10000);
		s = hrdata;
		if (n >= 10000) begin miscompares++; test_done(); end
	endtask : ahb
	task lb(input logic f, input logic [1:0] t, input logic [7:0] b);
		ahb(1'b1, 32'h0, {20'h0, f, 1'b0, t, b});
	endtask : lb
	task cmd(input logic [7:0] b); lb(1'b0, 2'h0, b); endtask : cmd
	task adr(input logic [7:0] b); lb(1'b0, 2'h1, b); endtask : adr
	task dat(input logic [7:0] b); lb(1'b0, 2'h2, b); endtask : dat
	task poll(input logic f);
		int n;
		n = 0;
		lb(f, 2'h3, 8'h00);
		repeat (3) @(posedge hclk);
		do begin ahb(1'b0, 32'h4, 32'h0); n++; end while (s[8] !== 1'b0 && n < 3000);
		if (n >= 3000) begin miscompares++; test_done(); end
	endtask : poll
	task setup(input logic [7:0] r1, input logic pl, input logic [5:0] pg, input logic [12:0] c);
		cmd(8'h80);
		adr(c[7:0]);
		adr({3'h0, c[12:8]});
		adr({1'b0, pl, pg});
		adr(r1);
		adr(8'h00);
	endtask : setup
	task peek(input logic pl, input logic [12:0] c, input logic [7:0] e);
		peek_plane <= pl;
		peek_col <= c;
		repeat (3) @(posedge hclk);
		chk({24'h0, peek_data}, {24'h0, e});
	endtask : peek
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		hresetn = 1'b0; hsel = 1'b1; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
		hwdata = 32'h0; fail_inject = 2'h0; peek_plane = 1'b0; peek_col = 13'h0000;
		rows[0] = '{8'h10, 6'h00, 13'h0000, 8'h5A, 2'h0, 8'h60};
		rows[1] = '{8'h10, 6'h01, 13'h10FF, 8'hA5, 2'h1, 8'h61};
		rows[2] = '{8'h15, 6'h02, 13'h0100, 8'h3C, 2'h0, 8'h60};
		rows[3] = '{8'h15, 6'h03, 13'h0200, 8'hC3, 2'h0, 8'h60};
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, 32'h4, 32'h0);
		chk({29'h0, s[10:8]}, 32'h4);
		ahb(1'b0, 32'h8, 32'h0);
		chk(s, 32'h100);
		ahb(1'b0, 32'hC, 32'h0);
		chk(s, 32'h0);
		prev = 13'h0800;
		foreach (rows[i]) begin
			setup(8'h00, 1'b0, rows[i].pg, rows[i].col);
			peek(1'b0, prev, 8'hFF);
			dat(rows[i].dat);
			peek(1'b0, rows[i].col, rows[i].dat);
			fail_inject <= rows[i].fi;
			cmd(rows[i].op);
			poll(1'b1);
			chk({24'h0, s[7:0] & 8'h61}, {24'h0, rows[i].st});
			prev = rows[i].col;
		end
		fail_inject <= 2'h0;
		setup(8'h01, 1'b0, 6'h00, 13'h0005);
		dat(8'hAA);
		cmd(8'h85);
		adr(8'h20);
		adr(8'h00);
		dat(8'hBB);
		peek(1'b0, 13'h0005, 8'hAA);
		peek(1'b0, 13'h0020, 8'hBB);
		cmd(8'h10);
		poll(1'b1);
		setup(8'h02, 1'b0, 6'h00, 13'h0007);
		dat(8'h11);
		cmd(8'h11);
		poll(1'b0);
		setup(8'h02, 1'b1, 6'h01, 13'h0007);
		dat(8'h22);
		peek(1'b0, 13'h0007, 8'h11);
		peek(1'b1, 13'h0007, 8'h22);
		fail_inject <= 2'h2;
		cmd(8'h10);
		poll(1'b1);
		chk({30'h0, prog_planes}, 32'h3);
		chk({24'h0, s[7:0] & 8'h6F}, 32'h69);
		setup(8'h03, 1'b0, 6'h00, 13'h0009);
		dat(8'h33);
		cmd(8'h11);
		poll(1'b0);
		setup(8'h03, 1'b1, 6'h01, 13'h0009);
		dat(8'h44);
		cmd(8'h15);
		poll(1'b0);
		chk({24'h0, s[7:0] & 8'h62}, 32'h42);
		setup(8'h03, 1'b0, 6'h02, 13'h0010);
		peek(1'b1, 13'h0009, 8'hFF);
		dat(8'h55);
		cmd(8'h15);
		poll(1'b1);
		chk({30'h0, prog_planes}, 32'h1);
		chk({24'h0, s[7:0] & 8'h63}, 32'h62);
		ahb(1'b1, 32'h8, 32'h0);
		setup(8'h03, 1'b0, 6'h01, 13'h0000);
		cmd(8'h10);
		poll(1'b1);
		ahb(1'b0, 32'h4, 32'h0);
		chk({31'h0, s[9]}, 32'h1);
		ahb(1'b1, 32'h4, 32'h200);
		ahb(1'b0, 32'h4, 32'h0);
		chk({31'h0, s[9]}, 32'h0);
		chk(32'(pulses), 32'h9);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		chk(hrdata, 32'h0);
		chk({30'h0, hreadyout, lnk.rb_n}, 32'h3);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, 32'h8, 32'h0);
		chk(s, 32'h100);
		ahb(1'b0, 32'h4, 32'h0);
		chk(s, 32'h400);
		test_done();
	end
endmodule : nand_page_program_sequencer_tb
